// File: core/bscx_exec.sv
// execution of bit skip, subroutine call and accumulator clear
// assumes the fetch pipeline presents one decoded word per enabled cycle
// and the register file returns the addressed file register combinationally
`timescale 1ns/1ns
`include "bscx_cfg.svh"

module bscx_exec
(
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // instruction from fetch
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr,
  input  wire logic [10:0] pc_cur,
  // operands
  input  wire logic [7:0]  file_data,
  input  wire logic [7:0]  status_in,
  // program counter and stack
  output logic             pc_load_ff,
  output logic [10:0]      pc_target_ff,
  output logic             stack_push_ff,
  output logic [10:0]      stack_top_entry_ff,
  output logic             fetch_discard,
  // accumulator and flags
  output logic             acc_write_ff,
  output logic [7:0]       acc_data_ff,
  output logic             zero_set_ff,
  output logic             busy
);

  logic                  rst_meta_ff;
  logic                  rst_sync_ff;
  bscx_pkg::bscx_state_t state_ff;
  bscx_pkg::bscx_state_t nxt_state;
  logic                  is_skip;
  logic                  is_call;
  logic                  is_clr;
  logic                  skip_taken;

  // ==========================================================
  // reset release
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================
  // decode
  function automatic logic op_hi_is(input logic [11:0] w,
                                    input logic [3:0]  op);
    op_hi_is = (w[`BSCX_OP_HI] == op);
  endfunction : op_hi_is

  // a word arriving in the flush cycle is the discarded one
  always_comb
  begin
    is_skip = instr_valid && (state_ff == bscx_pkg::BSCX_EXEC)
              && op_hi_is(instr, `BSCX_OP_SKIP);
    is_call = instr_valid && (state_ff == bscx_pkg::BSCX_EXEC)
              && op_hi_is(instr, `BSCX_OP_CALL);
    is_clr  = instr_valid && (state_ff == bscx_pkg::BSCX_EXEC)
              && (instr == `BSCX_OP_CLRACC);
    skip_taken = is_skip && file_data[instr[`BSCX_BIT_SEL]];
  end

  // ==========================================================
  // second cycle for taken skip and call
  always_comb
  begin
    nxt_state = bscx_pkg::BSCX_EXEC;
    case (state_ff)
      bscx_pkg::BSCX_EXEC:
      begin
        if (skip_taken || is_call)
        begin
          nxt_state = bscx_pkg::BSCX_FLUSH;
        end
      end
      default:
      begin
        nxt_state = bscx_pkg::BSCX_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff <= bscx_pkg::BSCX_EXEC;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
    end
  end

  assign busy          = (state_ff == bscx_pkg::BSCX_FLUSH);
  assign fetch_discard = busy;

  // ==========================================================
  // call: stack push and target build
  always_ff @(posedge clk_sys or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      stack_push_ff      <= 1'b0;
      stack_top_entry_ff <= `BSCX_PC_ZERO;
      pc_load_ff         <= 1'b0;
      pc_target_ff       <= `BSCX_PC_ZERO;
    end
    else if (clk_en)
    begin
      stack_push_ff <= is_call;
      pc_load_ff    <= is_call;
      if (is_call)
      begin
        stack_top_entry_ff <= pc_cur + `BSCX_PC_ONE;
        // page from status, bit 8 cleared, low byte immediate
        pc_target_ff <= {status_in[`BSCX_ST_PAGE], 1'b0,
                         instr[`BSCX_IMM]};
      end
    end
  end

  // ==========================================================
  // accumulator clear; skip and call never touch flags
  always_ff @(posedge clk_sys or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      acc_write_ff <= 1'b0;
      acc_data_ff  <= `BSCX_ACC_ZERO;
      zero_set_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      acc_write_ff <= is_clr;
      zero_set_ff  <= is_clr;
      acc_data_ff  <= `BSCX_ACC_ZERO;
    end
  end

  // ==========================================================
  // checks
  sequence s_call_seen;
    clk_en && is_call;
  endsequence

  property p_skip_flush;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    (clk_en && skip_taken) |=> fetch_discard;
  endproperty
  a_skip_flush: assert property (p_skip_flush)
    else $error("taken skip did not flush next word");

  property p_skip_clear_no_flush;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    (clk_en && is_skip && !skip_taken) |=> !fetch_discard;
  endproperty
  a_skip_clear_no_flush: assert property (p_skip_clear_no_flush)
    else $error("untaken skip flushed a word");

  property p_push_value;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    s_call_seen |=> stack_push_ff
      && stack_top_entry_ff == $past(pc_cur) + `BSCX_PC_ONE;
  endproperty
  a_push_value: assert property (p_push_value)
    else $error("call pushed wrong return address");

  property p_target_low;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    s_call_seen |=> pc_target_ff[`BSCX_IMM] == $past(instr[`BSCX_IMM]);
  endproperty
  a_target_low: assert property (p_target_low)
    else $error("call target low byte wrong");

  property p_target_page;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    s_call_seen |=> pc_load_ff
      && pc_target_ff[`BSCX_PC_PAGE] == $past(status_in[`BSCX_ST_PAGE]);
  endproperty
  a_target_page: assert property (p_target_page)
    else $error("call page bits wrong");

  property p_call_two;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    s_call_seen |=> busy && !pc_target_ff[`BSCX_PC_HALF] && !zero_set_ff;
  endproperty
  a_call_two: assert property (p_call_two)
    else $error("call not two cycles or bit 8 set");

  property p_clr;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    (clk_en && is_clr) |=> acc_write_ff && zero_set_ff
      && acc_data_ff == `BSCX_ACC_ZERO && !busy;
  endproperty
  a_clr: assert property (p_clr)
    else $error("accumulator clear wrong");

  property p_flush_one;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    (clk_en && busy) |=> !busy;
  endproperty
  a_flush_one: assert property (p_flush_one)
    else $error("flush lasted more than one cycle");

endmodule : bscx_exec

// File: core/bscx_cfg.svh
// constants for the skip, call and clear-accumulator execution block
// assumes a 12-bit instruction word and an 11-bit program counter
`ifndef BSCX_CFG_SVH
`define BSCX_CFG_SVH

`define BSCX_OP_SKIP      4'h7
`define BSCX_OP_CALL      4'h9
`define BSCX_OP_CLRACC    12'h040
`define BSCX_OP_HI        11:8
`define BSCX_BIT_SEL      7:5
`define BSCX_IMM          7:0
`define BSCX_ST_PAGE      6:5
`define BSCX_ST_ZERO      2
`define BSCX_PC_ONE       11'h001
`define BSCX_ACC_ZERO     8'h00
`define BSCX_PC_ZERO      11'h000
`define BSCX_PC_PAGE      10:9
`define BSCX_PC_HALF      8

`endif

// File: core/bscx_pkg.sv
// types for the skip, call and clear-accumulator execution block
// assumes nothing beyond the constants header
package bscx_pkg;

  typedef enum logic [1:0]
  {
    BSCX_EXEC,
    BSCX_FLUSH
  } bscx_state_t;

endpackage : bscx_pkg

// File: verif/bscx_regfile_model.sv
// register file model answering the addressed file register
// assumes fixed contents, mirrored by the bench's own reckoning
`timescale 1ns/1ns

module bscx_regfile_model
(
  // address from the instruction word
  input  wire logic [4:0] addr,
  // content, combinational like the real file
  output logic      [7:0] rd_data
);
  // pattern mixes ones and zeros so both skip outcomes occur
  assign rd_data = {addr, addr[2:0]} ^ 8'hA5;
endmodule : bscx_regfile_model

// File: verif/test_bit_skip_call_clear_exec.sv
// self-checking bench for the skip, call and clear execution block
// assumes outputs answer one clock after an accepted word
`timescale 1ns/1ns

module test_bit_skip_call_clear_exec;
  logic        clk_sys, arst_n, clk_en, instr_valid;
  logic        pc_load_ff, stack_push_ff, fetch_discard;
  logic        acc_write_ff, zero_set_ff, busy;
  logic [11:0] instr, w;
  logic [10:0] pc_cur, pc_target_ff, stack_top_entry_ff;
  logic [7:0]  file_data, status_in, acc_data_ff;
  integer      error_cnt, num_checks, seed, i, r;

  bscx_exec DUT
  (
    .clk_sys            (clk_sys),
    .arst_n             (arst_n),
    .clk_en             (clk_en),
    .instr_valid        (instr_valid),
    .instr              (instr),
    .pc_cur             (pc_cur),
    .file_data          (file_data),
    .status_in          (status_in),
    .pc_load_ff         (pc_load_ff),
    .pc_target_ff       (pc_target_ff),
    .stack_push_ff      (stack_push_ff),
    .stack_top_entry_ff (stack_top_entry_ff),
    .fetch_discard      (fetch_discard),
    .acc_write_ff       (acc_write_ff),
    .acc_data_ff        (acc_data_ff),
    .zero_set_ff        (zero_set_ff),
    .busy               (busy)
  );
  bscx_regfile_model model (.addr(instr[4:0]), .rd_data(file_data));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] reg_val(input logic [4:0] a);
    return {a, a[2:0]} ^ 8'hA5;
  endfunction : reg_val

  task automatic chk(input string what, input logic [10:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("%0d checks, %0d mismatches", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic exec(input logic [11:0] wd, input logic [10:0] pc,
    input logic [7:0] st);
    logic       call, skp, clr;
    logic [7:0] v;
    v = reg_val(wd[4:0]);
    call = wd[11:8] == 4'h9;
    skp = wd[11:8] == 4'h7 && v[wd[7:5]];
    clr = wd == 12'h040;
    instr = wd;
    pc_cur = pc;
    status_in = st;
    @(negedge clk_sys);
    chk("push", 11'(call), 11'(stack_push_ff));
    chk("load", 11'(call), 11'(pc_load_ff));
    if (call)
    begin
      chk("return", pc + 11'h001, stack_top_entry_ff);
      chk("target low", 11'(wd[7:0]), 11'(pc_target_ff[7:0]));
      chk("target page", 11'(st[6:5]), 11'(pc_target_ff[10:9]));
      chk("target bit8", 11'h000, 11'(pc_target_ff[8]));
    end
    chk("busy", 11'(call | skp), 11'(busy));
    chk("discard", 11'(call | skp), 11'(fetch_discard));
    chk("acc write", 11'(clr), 11'(acc_write_ff));
    chk("zero", 11'(clr), 11'(zero_set_ff));
    if (clr)
      chk("acc data", 11'h000, 11'(acc_data_ff));
    if (call | skp)
    begin
      // a clear offered in the flush cycle must be dropped
      instr = 12'h040;
      @(negedge clk_sys);
      chk("ignored", 11'h000, 11'({acc_write_ff, busy}));
      chk("ignored push", 11'h000, 11'(stack_push_ff));
    end
  endtask : exec

  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    seed = 26;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr = 12'h000;
    pc_cur = 11'h000;
    status_in = 8'h00;
    arst_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    instr_valid = 1'b1;
    exec(12'h9FF, 11'h7FF, 8'hFF);
    exec(12'h900, 11'h123, 8'h9F);
    exec(12'h7E0, 11'h010, 8'h00);
    exec(12'h7C0, 11'h011, 8'h00);
    exec(12'h040, 11'h012, 8'hFF);
    exec(12'h040, 11'h013, 8'h00);
    // enable low: pulses stand, a pending call waits for enable
    clk_en = 1'b0;
    instr = 12'h9A5;
    pc_cur = 11'h200;
    status_in = 8'h40;
    @(negedge clk_sys);
    chk("frozen acc write", 11'h001, 11'(acc_write_ff));
    chk("frozen push", 11'h000, 11'(stack_push_ff));
    clk_en = 1'b1;
    exec(12'h9A5, 11'h200, 8'h40);
    // a word without valid must leave no trace
    instr_valid = 1'b0;
    instr = 12'h040;
    @(negedge clk_sys);
    chk("no valid", 11'h000, 11'({acc_write_ff, zero_set_ff}));
    // reset in mid-run clears every pulse and register
    arst_n = 1'b0;
    @(negedge clk_sys);
    chk("reset", 11'h000, 11'({pc_load_ff, stack_push_ff, busy}));
    chk("reset acc", 11'h000, 11'({acc_write_ff, zero_set_ff}));
    chk("reset target", 11'h000, pc_target_ff);
    chk("reset return", 11'h000, stack_top_entry_ff);
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    // internal reset lifts at the second edge; first word at the fourth
    repeat (3) @(negedge clk_sys);
    instr_valid = 1'b1;
    $display("corner cases done");
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      w = r[13] ? (r[12] ? r[11:0] : 12'h040) : {r[12] ? 4'h9 : 4'h7, r[7:0]};
      exec(w, r[26:16], r[31:24]);
    end
    $display("random run done");
    wrap_up();
  end

  // run needs at most about 640 cycles; limit of 10000 leaves wide margin
  initial
  begin
    #500000;
    error_cnt++;
    wrap_up();
  end
endmodule : test_bit_skip_call_clear_exec
